// File: hdl/fmsc_pkg.sv
// Shared constants and types of the fused multiply-add special-case unit
package fmsc_pkg;

	// ------------------------------------------------------------
	// Operand field layout
	// ------------------------------------------------------------
	localparam int OPND_W = 64;
	localparam int SP_SIGN = 31;
	localparam int SP_EXP_LO = 23;
	localparam int DP_SIGN = 63;
	localparam int DP_EXP_LO = 52;
	localparam logic [31:0] SP_QNAN_DEFAULT = 32'hFFC00000;
	localparam logic [63:0] DP_QNAN_DEFAULT = 64'hFFF8000000000000;
	localparam logic [7:0] SP_EXP_MAX = 8'hFF;
	localparam logic [10:0] DP_EXP_MAX = 11'h7FF;

	// ------------------------------------------------------------
	// Rounding modes and exception flag positions
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		FMSC_RND_NEAR = 2'h0,
		FMSC_RND_DOWN = 2'h1,
		FMSC_RND_UP = 2'h2,
		FMSC_RND_ZERO = 2'h3
	} fmsc_rnd_e;
	localparam int EXC_W = 5;
	localparam int EXC_INV = 0;
	localparam int EXC_DEN = 1;
	localparam int EXC_OVF = 2;
	localparam int EXC_UNF = 3;
	localparam int EXC_INX = 4;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam int REG_AW = 4;
	localparam int REG_DW = 32;
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h4;
	localparam logic [3:0] OFS_IRQ_MASK = 4'h8;
	localparam logic [3:0] OFS_FEATURE = 4'hC;
	localparam int CTRL_RND_LO = 0;
	localparam int CTRL_MASK_LO = 2;
	localparam logic [6:0] CTRL_RESET = 7'h7C;
	localparam logic [4:0] IRQ_MASK_RESET = 5'h00;
	localparam logic [4:0] STATUS_RESET = 5'h00;
	localparam int FEAT_V128_BIT = 0;
	localparam int FEAT_V256_BIT = 1;
	localparam int FEAT_FMA_BIT = 12;
	localparam int VEC_NARROW_W = 128;
	localparam int VEC_WIDE_W = 256;

endpackage

// File: hdl/fmsc_class.sv
// Operand classifier for single or double precision values
module fmsc_class (
	input wire logic [63:0] opnd,
	input wire logic dbl,
	output logic sign,
	output logic is_nan,
	output logic is_snan,
	output logic is_inf,
	output logic is_zero,
	output logic is_den
);

	logic exp_max;
	logic exp_min;
	logic frac_nz;
	logic qbit;

	// Field extraction by precision
	always_comb begin
		if (dbl) begin
			sign = opnd[fmsc_pkg::DP_SIGN];
			exp_max = &opnd[fmsc_pkg::DP_SIGN-1:fmsc_pkg::DP_EXP_LO];
			exp_min = ~|opnd[fmsc_pkg::DP_SIGN-1:fmsc_pkg::DP_EXP_LO];
			frac_nz = |opnd[fmsc_pkg::DP_EXP_LO-1:0];
			qbit = opnd[fmsc_pkg::DP_EXP_LO-1];
		end else begin
			sign = opnd[fmsc_pkg::SP_SIGN];
			exp_max = &opnd[fmsc_pkg::SP_SIGN-1:fmsc_pkg::SP_EXP_LO];
			exp_min = ~|opnd[fmsc_pkg::SP_SIGN-1:fmsc_pkg::SP_EXP_LO];
			frac_nz = |opnd[fmsc_pkg::SP_EXP_LO-1:0];
			qbit = opnd[fmsc_pkg::SP_EXP_LO-1];
		end
	end

	// Class flags
	assign is_nan = exp_max & frac_nz;
	assign is_snan = is_nan & ~qbit;
	assign is_inf = exp_max & ~frac_nz;
	assign is_zero = exp_min & ~frac_nz;
	assign is_den = exp_min & frac_nz;

endmodule

// File: hdl/fmsc_quiet.sv
// Quietizer: sets the leading fraction bit of a NaN
module fmsc_quiet (
	input wire logic [63:0] opnd,
	input wire logic dbl,
	output logic [63:0] quiet
);

	// Quiet NaN passes unchanged, signalling NaN gains its quiet bit
	always_comb begin
		quiet = opnd;
		if (dbl) begin
			quiet[fmsc_pkg::DP_EXP_LO-1] = 1'b1;
		end else begin
			quiet[fmsc_pkg::SP_EXP_LO-1] = 1'b1;
			quiet[63:32] = 32'h00000000;
		end
	end

endmodule

// File: hdl/fmsc_top.sv
// Special-operand and result selection for a fused multiply-add unit
//Function
//RULE1 - NaN multiplicand gives it quietized; any sNaN raises invalid
//RULE2 - Else NaN multiplier: quietized; invalid if it or addend is sNaN
//RULE3 - Only addend NaN returns it quietized; invalid only if it signals
//RULE4 - Infinite product and addend: same sign keeps it, else default NaN
//RULE5 - Infinite product, finite or zero addend: infinity of product sign
//RULE6 - Infinity times zero gives default quiet NaN and raises invalid
//RULE7 - Finite product, infinite addend: infinity of effective addend sign
//RULE8 - Zero product plus zero addend gives zero signed by operands and mode
//RULE9 - Finite nonzero product with zero addend returns the rounded product
//RULE10 - Exact cancellation gives zero signed by the mode; else round once
//RULE11 - Unmasked exception keeps destination contents and traps to handler
//RULE12 - Identification register reports fused multiply-add support at bit 12
//RULE13 - Software checks feature bits and vector state enables before use
//RULE14 - Both 128-bit and 256-bit vector forms are provided
//RULE15 - Default quiet NaN: sign one, top fraction bit one, rest zero
//RULE16 - Quietizing keeps a quiet NaN and quiets a signalling one
//RULE17 - Opposite-sign zero sum is minus zero under round-down, else plus
//RULE18 - Every invalid case sets the invalid flag in the status register
//
// Added by the designer: the register offsets and the address-and-strobe port.
module fmsc_top (
	input wire logic MCLK,
	input wire logic RESET,
	input wire logic OP_VALID,
	input wire logic [63:0] OP_X,
	input wire logic [63:0] OP_Y,
	input wire logic [63:0] OP_Z,
	input wire logic OP_DOUBLE,
	input wire logic OP_NEG_PROD,
	input wire logic OP_SUB_ADDEND,
	input wire logic [63:0] OP_DEST,
	input wire logic [63:0] ARITH_RESULT,
	input wire logic ARITH_OVERFLOW,
	input wire logic ARITH_UNDERFLOW,
	input wire logic ARITH_INEXACT,
	output logic RES_VALID,
	output logic [63:0] RES_DATA,
	output logic RES_WRITE,
	output logic FP_TRAP,
	output logic [4:0] EXC_FLAGS,
	input wire logic [3:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [31:0] REG_RDATA,
	output logic IRQ
);

	// ------------------------------------------------------------
	// Operand classification
	// ------------------------------------------------------------
	logic [63:0] opnd [3];
	logic [63:0] qv [3];
	logic [2:0] sgn;
	logic [2:0] nan;
	logic [2:0] snan;
	logic [2:0] inf;
	logic [2:0] zero;
	logic [2:0] den;

	assign opnd[0] = OP_X;
	assign opnd[1] = OP_Y;
	assign opnd[2] = OP_Z;

	// One classifier and one quietizer per source operand
	for (genvar i = 0; i < 3; i++) begin : g_opnd
		fmsc_class u_class (
			.opnd(opnd[i]),
			.dbl(OP_DOUBLE),
			.sign(sgn[i]),
			.is_nan(nan[i]),
			.is_snan(snan[i]),
			.is_inf(inf[i]),
			.is_zero(zero[i]),
			.is_den(den[i])
		);
		fmsc_quiet u_quiet (
			.opnd(opnd[i]),
			.dbl(OP_DOUBLE),
			.quiet(qv[i])
		);
	end

	// ------------------------------------------------------------
	// Control, status and mask registers
	// ------------------------------------------------------------
	logic [6:0] ctrl;
	logic [4:0] status;
	logic [4:0] irq_mask;
	logic [1:0] rnd_mode;
	logic [4:0] exc_mask;
	logic wr_ctrl;
	logic wr_status;
	logic wr_mask;

	assign rnd_mode = ctrl[fmsc_pkg::CTRL_RND_LO+:2];
	assign exc_mask = ctrl[fmsc_pkg::CTRL_MASK_LO+:fmsc_pkg::EXC_W];
	assign wr_ctrl = REG_WR && (REG_ADDR == fmsc_pkg::OFS_CTRL);
	assign wr_status = REG_WR && (REG_ADDR == fmsc_pkg::OFS_STATUS);
	assign wr_mask = REG_WR && (REG_ADDR == fmsc_pkg::OFS_IRQ_MASK);

	// Rounding mode and exception masks
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			ctrl <= fmsc_pkg::CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl <= REG_WDATA[6:0];
		end
	end

	// Interrupt mask
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			irq_mask <= fmsc_pkg::IRQ_MASK_RESET;
		end else if (wr_mask) begin
			irq_mask <= REG_WDATA[4:0];
		end
	end

	// ------------------------------------------------------------
	// Value builders
	// ------------------------------------------------------------
	function automatic logic [63:0] mk_inf(input logic s, input logic d);
		if (d) begin
			mk_inf = {s, fmsc_pkg::DP_EXP_MAX, 52'h0};
		end else begin
			mk_inf = {32'h0, s, fmsc_pkg::SP_EXP_MAX, 23'h0};
		end
	endfunction

	function automatic logic [63:0] mk_zero(input logic s, input logic d);
		if (d) begin
			mk_zero = {s, 63'h0};
		end else begin
			mk_zero = {32'h0, s, 31'h0};
		end
	endfunction

	function automatic logic [63:0] mk_sign(input logic [63:0] v,
		input logic s, input logic d);
		mk_sign = v;
		if (d) begin
			mk_sign[fmsc_pkg::DP_SIGN] = s;
		end else begin
			mk_sign[fmsc_pkg::SP_SIGN] = s;
		end
	endfunction

	// ------------------------------------------------------------
	// Special-case result selection
	// ------------------------------------------------------------
	logic prod_sign;
	logic add_sign;
	logic rnd_down;
	logic prod_inf;
	logic prod_zero;
	logic inf_x_zero;
	logic arith_zero;
	logic [63:0] dq_nan;
	logic [63:0] next_res;
	logic next_inv;
	logic arith_path;

	assign prod_sign = sgn[0] ^ sgn[1] ^ OP_NEG_PROD;
	assign add_sign = sgn[2] ^ OP_SUB_ADDEND;
	assign rnd_down = (rnd_mode == fmsc_pkg::FMSC_RND_DOWN);
	assign prod_inf = inf[0] | inf[1];
	assign prod_zero = zero[0] | zero[1];
	assign inf_x_zero = (inf[0] & zero[1]) | (zero[0] & inf[1]);
	assign arith_zero = OP_DOUBLE ? ~|ARITH_RESULT[62:0] :
		~|ARITH_RESULT[30:0];
	assign dq_nan = OP_DOUBLE ? fmsc_pkg::DP_QNAN_DEFAULT : // RULE15
		{32'h0, fmsc_pkg::SP_QNAN_DEFAULT};

	// Priority chain over operand classes
	always_comb begin
		next_res = ARITH_RESULT;
		next_inv = 1'b0;
		arith_path = 1'b0;
		if (nan[0]) begin
			next_res = qv[0]; // RULE1 RULE16
			next_inv = |snan;
		end else if (nan[1]) begin
			next_res = qv[1]; // RULE2
			next_inv = snan[1] | snan[2];
		end else if (nan[2]) begin
			next_res = qv[2]; // RULE3
			next_inv = snan[2];
		end else if (inf_x_zero) begin
			next_res = dq_nan; // RULE6
			next_inv = 1'b1;
		end else if (prod_inf && inf[2]) begin
			if (prod_sign == add_sign) begin
				next_res = mk_inf(prod_sign, OP_DOUBLE); // RULE4
			end else begin
				next_res = dq_nan; // RULE4
				next_inv = 1'b1;
			end
		end else if (prod_inf) begin
			next_res = mk_inf(prod_sign, OP_DOUBLE); // RULE5
		end else if (inf[2]) begin
			next_res = mk_inf(add_sign, OP_DOUBLE); // RULE7
		end else if (prod_zero && zero[2]) begin
			if (prod_sign == add_sign) begin
				next_res = mk_zero(prod_sign, OP_DOUBLE); // RULE8
			end else begin
				next_res = mk_zero(rnd_down, OP_DOUBLE); // RULE17
			end
		end else if (prod_zero) begin
			next_res = mk_sign(OP_Z, add_sign, OP_DOUBLE); // RULE10
		end else if (zero[2]) begin
			next_res = ARITH_RESULT; // RULE9
			arith_path = 1'b1;
		end else begin
			arith_path = 1'b1;
			if (arith_zero && !ARITH_INEXACT) begin
				next_res = mk_zero(rnd_down, OP_DOUBLE); // RULE10 RULE17
			end
		end
	end

	// ------------------------------------------------------------
	// Exceptions and destination update
	// ------------------------------------------------------------
	logic [4:0] raised;
	logic unmasked;

	// Exception vector of the current operation
	always_comb begin
		raised = '0;
		raised[fmsc_pkg::EXC_INV] = next_inv;
		raised[fmsc_pkg::EXC_DEN] = |den & ~|nan;
		raised[fmsc_pkg::EXC_OVF] = arith_path & ARITH_OVERFLOW;
		raised[fmsc_pkg::EXC_UNF] = arith_path & ARITH_UNDERFLOW;
		raised[fmsc_pkg::EXC_INX] = arith_path & ARITH_INEXACT;
	end

	assign unmasked = |(raised & ~exc_mask);

	// Result register; a trapped operation returns the old destination
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			RES_VALID <= 1'b0;
			RES_DATA <= '0;
			RES_WRITE <= 1'b0;
			FP_TRAP <= 1'b0;
			EXC_FLAGS <= '0;
		end else begin
			RES_VALID <= OP_VALID;
			RES_WRITE <= OP_VALID & ~unmasked; // RULE11
			FP_TRAP <= OP_VALID & unmasked; // RULE11
			EXC_FLAGS <= OP_VALID ? raised : '0;
			if (OP_VALID) begin
				RES_DATA <= unmasked ? OP_DEST : next_res; // RULE11
			end
		end
	end

	// Sticky status: a new event wins over a write-one clear
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			status <= fmsc_pkg::STATUS_RESET;
		end else begin
			status <= (status & ~(wr_status ? REG_WDATA[4:0] : 5'h00)) |
				(OP_VALID ? raised : 5'h00); // RULE18
		end
	end

	assign IRQ = |(status & irq_mask);

	// ------------------------------------------------------------
	// Register read port
	// ------------------------------------------------------------
	logic [31:0] feature;

	// Capability word: fused multiply-add and both vector widths
	always_comb begin
		feature = '0;
		feature[fmsc_pkg::FEAT_FMA_BIT] = 1'b1; // RULE12
		feature[fmsc_pkg::FEAT_V128_BIT] = // RULE14
			(fmsc_pkg::VEC_NARROW_W == 128);
		feature[fmsc_pkg::FEAT_V256_BIT] = // RULE14
			(fmsc_pkg::VEC_WIDE_W == 256);
	end

	// Read data stand for one cycle after the strobe
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			REG_RDATA <= '0;
		end else if (REG_RD) begin
			case (REG_ADDR)
				fmsc_pkg::OFS_CTRL: REG_RDATA <= {25'h0, ctrl};
				fmsc_pkg::OFS_STATUS: REG_RDATA <= {27'h0, status};
				fmsc_pkg::OFS_IRQ_MASK: REG_RDATA <= {27'h0, irq_mask};
				fmsc_pkg::OFS_FEATURE: REG_RDATA <= feature;
				default: REG_RDATA <= '0;
			endcase
		end else begin
			REG_RDATA <= '0;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (RESET);

	logic inv_masked;
	assign inv_masked = exc_mask[fmsc_pkg::EXC_INV];

	property p_x_nan;
		OP_VALID && nan[0] && inv_masked |=>
			RES_WRITE && RES_DATA == $past(qv[0]);
	endproperty
	a_x_nan: assert property (p_x_nan) // RULE1
		else $error("NaN multiplicand not returned quietized");
	property p_y_nan;
		OP_VALID && !nan[0] && nan[1] && snan[2] |=>
			EXC_FLAGS[fmsc_pkg::EXC_INV];
	endproperty
	a_y_nan: assert property (p_y_nan) // RULE2
		else $error("Signalling addend missed invalid");
	property p_z_only;
		OP_VALID && !nan[0] && !nan[1] && nan[2] && !snan[2] |=>
			!EXC_FLAGS[fmsc_pkg::EXC_INV];
	endproperty
	a_z_only: assert property (p_z_only) // RULE3
		else $error("Quiet addend NaN raised invalid");
	property p_inf_zero;
		OP_VALID && inf_x_zero && !(|nan) |=>
			EXC_FLAGS[fmsc_pkg::EXC_INV] && FP_TRAP == !$past(inv_masked);
	endproperty
	a_inf_zero: assert property (p_inf_zero) // RULE6
		else $error("Infinity times zero not invalid");
	property p_inf_cancel;
		OP_VALID && prod_inf && inf[2] && !(|nan) && !inf_x_zero &&
			prod_sign != add_sign && inv_masked |=> RES_DATA ==
			($past(OP_DOUBLE) ? fmsc_pkg::DP_QNAN_DEFAULT :
			{32'h0, fmsc_pkg::SP_QNAN_DEFAULT}) && EXC_FLAGS[fmsc_pkg::EXC_INV];
	endproperty
	a_inf_cancel: assert property (p_inf_cancel) // RULE4
		else $error("Opposite infinities did not give NaN");
	property p_trap_keep;
		OP_VALID && unmasked |=> FP_TRAP && !RES_WRITE &&
			RES_DATA == $past(OP_DEST);
	endproperty
	a_trap_keep: assert property (p_trap_keep) // RULE11
		else $error("Trapped operation changed destination");
	property p_inv_sticky;
		RES_VALID && EXC_FLAGS[fmsc_pkg::EXC_INV] |->
			status[fmsc_pkg::EXC_INV] ##1 (status[fmsc_pkg::EXC_INV] ||
			$past(wr_status && REG_WDATA[fmsc_pkg::EXC_INV]));
	endproperty
	a_inv_sticky: assert property (p_inv_sticky) // RULE18
		else $error("Invalid flag not held in status");
	property p_feature;
		REG_RD && REG_ADDR == fmsc_pkg::OFS_FEATURE |=>
			REG_RDATA[fmsc_pkg::FEAT_FMA_BIT] ##1 REG_RDATA == 32'h0 ||
			$past(REG_RD);
	endproperty
	a_feature: assert property (p_feature) // RULE12
		else $error("Feature bit not reported");
	property p_zero_sign;
		OP_VALID && prod_zero && zero[2] && !(|inf) && !(|nan) &&
			prod_sign != add_sign |=> ($past(OP_DOUBLE) ? RES_DATA[63] :
			RES_DATA[31]) == ($past(rnd_mode) == fmsc_pkg::FMSC_RND_DOWN);
	endproperty
	a_zero_sign: assert property (p_zero_sign) // RULE17
		else $error("Zero sum carries wrong sign");
endmodule

// File: bench/fmsc_issue_model.sv
// Issue-side model that presents one operation for each request
module fmsc_issue_model (
	input wire logic MCLK,
	input wire logic RESET,
	input wire logic go,
	input wire logic [63:0] x,
	input wire logic [63:0] y,
	input wire logic [63:0] z,
	input wire logic [2:0] f,
	input wire logic [63:0] dest,
	input wire logic [63:0] ares,
	input wire logic [2:0] cf,
	output logic OP_VALID,
	output logic [63:0] OP_X,
	output logic [63:0] OP_Y,
	output logic [63:0] OP_Z,
	output logic OP_DOUBLE,
	output logic OP_NEG_PROD,
	output logic OP_SUB_ADDEND,
	output logic [63:0] OP_DEST,
	output logic [63:0] ARITH_RESULT,
	output logic ARITH_OVERFLOW,
	output logic ARITH_UNDERFLOW,
	output logic ARITH_INEXACT
);
	timeunit 1ns;
	timeprecision 1ps;

	// One-cycle request; idle buses show the inverse of the last value
	always_ff @(posedge MCLK or posedge RESET) begin
		if (RESET) begin
			OP_VALID <= 1'b0;
			{OP_X, OP_Y, OP_Z, OP_DEST, ARITH_RESULT} <= '0;
			{OP_DOUBLE, OP_NEG_PROD, OP_SUB_ADDEND} <= 3'h0;
			{ARITH_OVERFLOW, ARITH_UNDERFLOW, ARITH_INEXACT} <= 3'h0;
		end else if (go) begin
			OP_VALID <= 1'b1;
			{OP_X, OP_Y, OP_Z, OP_DEST, ARITH_RESULT} <= {x, y, z, dest, ares};
			{OP_DOUBLE, OP_NEG_PROD, OP_SUB_ADDEND} <= f;
			{ARITH_OVERFLOW, ARITH_UNDERFLOW, ARITH_INEXACT} <= cf;
		end else begin
			OP_VALID <= 1'b0;
			{OP_X, OP_Y, OP_Z} <= ~{OP_X, OP_Y, OP_Z};
			{OP_DEST, ARITH_RESULT} <= ~{OP_DEST, ARITH_RESULT};
			{OP_DOUBLE, OP_NEG_PROD, OP_SUB_ADDEND} <= 3'h0;
			{ARITH_OVERFLOW, ARITH_UNDERFLOW, ARITH_INEXACT} <= 3'h0;
		end
	end
endmodule

// File: bench/fmsc_top_tb_top.sv
// Self-checking bench of the fused multiply-add special-case unit
module fmsc_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// Values and signals
	// ------------------------------------------------------------
	localparam logic [63:0] ONE = 64'h3F800000;
	localparam logic [63:0] NONE = 64'hBF800000;
	localparam logic [63:0] INF = 64'h7F800000;
	localparam logic [63:0] NINF = 64'hFF800000;
	localparam logic [63:0] NZ = 64'h80000000;
	localparam logic [63:0] QN = {32'h0, fmsc_pkg::SP_QNAN_DEFAULT};
	localparam logic [63:0] DST = 64'h0123456789ABCDEF;
	logic MCLK, RESET, go;
	logic [63:0] x, y, z, ares;
	logic [2:0] f, cf;
	logic OP_VALID, OP_DOUBLE, OP_NEG_PROD, OP_SUB_ADDEND;
	logic [63:0] OP_X, OP_Y, OP_Z, OP_DEST, ARITH_RESULT, RES_DATA;
	logic ARITH_OVERFLOW, ARITH_UNDERFLOW, ARITH_INEXACT;
	logic RES_VALID, RES_WRITE, FP_TRAP, IRQ, REG_WR, REG_RD;
	logic [4:0] EXC_FLAGS;
	logic [3:0] REG_ADDR;
	logic [31:0] REG_WDATA, REG_RDATA;
	int fail_count, total_checks;

	fmsc_issue_model i_fmsc_issue_model (.MCLK(MCLK), .RESET(RESET),
		.go(go), .x(x), .y(y), .z(z), .f(f), .dest(DST), .ares(ares),
		.cf(cf), .OP_VALID(OP_VALID), .OP_X(OP_X), .OP_Y(OP_Y),
		.OP_Z(OP_Z), .OP_DOUBLE(OP_DOUBLE), .OP_NEG_PROD(OP_NEG_PROD),
		.OP_SUB_ADDEND(OP_SUB_ADDEND), .OP_DEST(OP_DEST),
		.ARITH_RESULT(ARITH_RESULT), .ARITH_OVERFLOW(ARITH_OVERFLOW),
		.ARITH_UNDERFLOW(ARITH_UNDERFLOW), .ARITH_INEXACT(ARITH_INEXACT));

	fmsc_top i_fmsc_top (.MCLK(MCLK), .RESET(RESET), .OP_VALID(OP_VALID),
		.OP_X(OP_X), .OP_Y(OP_Y), .OP_Z(OP_Z), .OP_DOUBLE(OP_DOUBLE),
		.OP_NEG_PROD(OP_NEG_PROD), .OP_SUB_ADDEND(OP_SUB_ADDEND),
		.OP_DEST(OP_DEST), .ARITH_RESULT(ARITH_RESULT),
		.ARITH_OVERFLOW(ARITH_OVERFLOW), .ARITH_UNDERFLOW(ARITH_UNDERFLOW),
		.ARITH_INEXACT(ARITH_INEXACT), .RES_VALID(RES_VALID),
		.RES_DATA(RES_DATA), .RES_WRITE(RES_WRITE), .FP_TRAP(FP_TRAP),
		.EXC_FLAGS(EXC_FLAGS), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
		.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .IRQ(IRQ));

	// 50 MHz clock
	always #10 MCLK = ~MCLK;

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	// Verdict and end of run
	task automatic summarize();
		if (fail_count == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// One comparison
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Register write, one strobe cycle
	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge MCLK);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge MCLK);
		REG_WR <= 1'b0;
	endtask

	// Register read, data taken in the cycle after the strobe
	task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge MCLK);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge MCLK);
		REG_RD <= 1'b0;
		#1;
		chk({32'h0, REG_RDATA}, {32'h0, e});
	endtask

	// One operation through the issue model, result judged
	task automatic op(input logic [63:0] a, b, c, input logic [2:0] m,
		input logic [63:0] r, input logic [2:0] k,
		input logic [63:0] ed, input logic [4:0] ef, input logic ew);
		int n;
		@(posedge MCLK);
		{x, y, z, f, ares, cf} <= {a, b, c, m, r, k};
		go <= 1'b1;
		@(posedge MCLK);
		go <= 1'b0;
		#1;
		for (n = 0; n < 4 && RES_VALID !== 1'b1; n++) begin
			@(posedge MCLK);
			#1;
		end
		if (RES_VALID !== 1'b1) begin
			chk({63'h0, RES_VALID}, 64'h1);
			summarize();
		end else begin
			chk(RES_DATA, ed);
			chk({59'h0, EXC_FLAGS}, {59'h0, ef});
			chk({62'h0, RES_WRITE, FP_TRAP}, {62'h0, ew, ~ew});
		end
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	// Identification, reset values and an unmapped place
	task automatic t_regs();
		reg_rd(fmsc_pkg::OFS_FEATURE, 32'h1003);
		reg_rd(fmsc_pkg::OFS_FEATURE, 32'h1003);
		reg_wr(fmsc_pkg::OFS_FEATURE, 32'h0);
		reg_rd(fmsc_pkg::OFS_FEATURE, 32'h1003);
		reg_rd(fmsc_pkg::OFS_CTRL, 32'h7C);
		reg_rd(4'h2, 32'h0);
	endtask

	// NaN operands, quietizing and invalid
	task automatic t_nan();
		op(64'h7FC00005, ONE, 64'h7F800002, 0, 0, 0, 64'h7FC00005, 1, 1);
		op(64'h7F800001, ONE, ONE, 0, 0, 0, 64'h7FC00001, 1, 1);
		op(64'h3FF0000000000000, 64'h7FF0000000000001, 0, 3'h4, 0, 0,
			64'h7FF8000000000001, 1, 1);
		op(ONE, 64'h7FC00000, 64'h7F800001, 0, 0, 0, 64'h7FC00000, 1, 1);
		op(ONE, ONE, 64'hFFC00007, 3'h1, 0, 0, 64'hFFC00007, 0, 1);
		op(ONE, ONE, 64'h7F800003, 0, 0, 0, 64'h7FC00003, 1, 1);
	endtask

	// Infinities and infinity times zero
	task automatic t_inf();
		op(INF, ONE, NINF, 0, 0, 0, QN, 1, 1);
		op(INF, ONE, NINF, 3'h1, 0, 0, INF, 0, 1);
		op(INF, NONE, ONE, 3'h2, 0, 0, INF, 0, 1);
		op(INF, NONE, 0, 0, 0, 0, NINF, 0, 1);
		op(0, INF, ONE, 3'h3, 0, 0, QN, 1, 1);
		op(64'h7FF0000000000000, 0, 0, 3'h4, 0, 0,
			fmsc_pkg::DP_QNAN_DEFAULT, 1, 1);
		op(ONE, ONE, INF, 3'h1, 0, 0, NINF, 0, 1);
		op(NONE, 0, NINF, 3'h3, 0, 0, INF, 0, 1);
	endtask

	// Zero results under three rounding modes, finite pass-through
	task automatic t_zero();
		reg_wr(fmsc_pkg::OFS_CTRL, 32'h7D);
		op(0, 0, NZ, 0, 0, 0, NZ, 0, 1);
		op(NZ, 0, NZ, 0, 0, 0, NZ, 0, 1);
		op(ONE, ONE, ONE, 3'h1, 0, 0, NZ, 0, 1);
		reg_wr(fmsc_pkg::OFS_CTRL, 32'h7E);
		op(0, 0, NZ, 0, 0, 0, 0, 0, 1);
		reg_wr(fmsc_pkg::OFS_CTRL, 32'h7C);
		op(0, ONE, ONE, 3'h1, 0, 0, NONE, 0, 1);
		op(0, 0, NZ, 0, 0, 0, 0, 0, 1);
		op(NZ, 0, 0, 3'h1, 0, 0, NZ, 0, 1);
		op(ONE, ONE, ONE, 3'h1, 0, 0, 0, 0, 1);
		op(ONE, 64'h40000000, 0, 3'h2, 64'hC0000000, 3'h1,
			64'hC0000000, 5'h10, 1);
	endtask

	// Unmasked invalid traps, status, interrupt raise and clear
	task automatic t_trap();
		reg_wr(fmsc_pkg::OFS_CTRL, 32'h78);
		op(INF, 0, ONE, 0, 0, 0, DST, 1, 0);
		reg_rd(fmsc_pkg::OFS_STATUS, 32'h11);
		reg_wr(fmsc_pkg::OFS_IRQ_MASK, 32'h1);
		#1;
		chk({63'h0, IRQ}, 64'h1);
		reg_wr(fmsc_pkg::OFS_STATUS, 32'h1);
		#1;
		chk({63'h0, IRQ}, 64'h0);
		reg_rd(fmsc_pkg::OFS_STATUS, 32'h10);
		reg_rd(fmsc_pkg::OFS_IRQ_MASK, 32'h1);
		reg_wr(fmsc_pkg::OFS_CTRL, 32'h3C);
		op(ONE, ONE, ONE, 0, INF, 3'h7, DST, 5'h1C, 0);
		reg_rd(fmsc_pkg::OFS_STATUS, 32'h1C);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		MCLK = 1'b0;
		RESET = 1'b1;
		{go, REG_WR, REG_RD, f, cf} = '0;
		{x, y, z, ares, REG_ADDR, REG_WDATA} = '0;
		fail_count = 0;
		total_checks = 0;
		repeat (3) @(posedge MCLK);
		RESET <= 1'b0;
		t_regs();
		t_nan();
		t_inf();
		t_zero();
		t_trap();
		summarize();
	end
endmodule
